// [bef_pkg.sv]
// package for the bridge error forwarding block
package bef_pkg;

  // register word offsets
  localparam logic [3:0] ADDR_ERR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_INT_MASK    = 4'h1;
  localparam logic [3:0] ADDR_CONTROL     = 4'h2;
  localparam logic [3:0] ADDR_ERR_MASK    = 4'h3;
  localparam logic [3:0] ADDR_SEVERITY    = 4'h4;
  localparam logic [3:0] ADDR_HEADER_LOG  = 4'h5;
  localparam logic [3:0] ADDR_FIRST_PTR   = 4'h6;

  // pointer register: source in [2:0], valid flag at this bit
  localparam int PTR_VALID = 3;

  // error sources, bit position in mask and severity
  localparam int ERR_TA_POSTED  = 0;
  localparam int ERR_TA_NP      = 1;
  localparam int ERR_UDE_NP     = 2;
  localparam int ERR_UDE_POSTED = 3;
  localparam int NUM_ERR        = 4;

  // status register bit positions
  localparam int ST_RX_TA_SEC     = 0;
  localparam int ST_RX_TA_UNC     = 1;
  localparam int ST_DET_PAR       = 2;
  localparam int ST_UNC_DATA      = 3;
  localparam int ST_MDPE_DET      = 4;
  localparam int ST_MDPE_PRI      = 5;
  localparam int ST_SIG_SERR      = 6;
  localparam int ST_FATAL_DET     = 7;
  localparam int ST_NONFATAL_DET  = 8;
  localparam int ST_W             = 9;

  // control register bit positions
  localparam int CT_SYSTEM_ERROR_ENABLE     = 0;
  localparam int CT_FATAL_EN    = 1;
  localparam int CT_NONFATAL_EN = 2;
  localparam int CT_PERESP_EN   = 3;
  localparam int CT_MA_MODE     = 4;
  localparam int CT_W           = 5;

  // reset values; master-abort mode starts cleared
  localparam logic [CT_W-1:0]    CONTROL_RST = 5'h00;
  localparam logic [NUM_ERR-1:0] MASK_RST    = 4'h0;
  localparam logic [NUM_ERR-1:0] SEV_RST     = 4'h0;
  localparam logic [31:0]        ALL_ONES    = 32'hFFFF_FFFF;

  // completion status encodings
  localparam logic [2:0] CPL_SC = 3'h0;
  localparam logic [2:0] CPL_UR = 3'h1;
  localparam logic [2:0] CPL_CA = 3'h4;

  // delayed transaction kinds
  typedef enum logic [1:0] {
    BEF_DT_MEM_READ = 2'h0,
    BEF_DT_IO_READ  = 2'h1,
    BEF_DT_IO_WRITE = 2'h2
  } bef_dt_kind_t;

  // parallel-bus immediate response
  typedef enum logic [1:0] {
    BEF_RSP_NORMAL = 2'h0,
    BEF_RSP_TABORT = 2'h1
  } bef_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        posted;
    logic [31:0] header;
  } bef_down_event_t;

  typedef struct packed {
    logic        valid;
    logic        posted;
    logic [31:0] header;
    logic [31:0] data;
  } bef_up_write_t;

  typedef struct packed {
    logic         valid;
    bef_dt_kind_t kind;
    logic [2:0]   status;
    logic [31:0]  data;
  } bef_dt_cpl_t;

  typedef struct packed {
    logic        valid;
    logic        poisoned;
    logic [31:0] header;
    logic [31:0] data;
  } bef_up_fwd_t;

  typedef struct packed {
    logic       valid;
    bef_rsp_t   rsp;
    logic [31:0] data;
  } bef_dt_rsp_t;

endpackage

// [bef_top.sv]
// bridge error forwarding logic with an avalon-mm register slave
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bef_top
  import bef_pkg::*;
(
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire logic [3:0]      i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  output logic [31:0]          o_avs_readdata,
  output logic                 o_avs_waitrequest,
  input  wire bef_down_event_t i_ta_event,
  input  wire bef_up_write_t   i_up_write,
  input  wire bef_dt_cpl_t     i_dt_cpl,
  output bef_up_fwd_t          o_up_fwd,
  output bef_dt_rsp_t          o_dt_rsp,
  output logic                 o_posted_drop,
  output logic                 o_ca_cpl,
  output logic                 o_np_discard,
  output logic                 o_perr_out,
  output logic                 o_perr_oe,
  output logic                 o_fatal_msg,
  output logic                 o_nonfatal_msg,
  output logic                 o_irq
);

  logic [ST_W-1:0]    status;
  logic [ST_W-1:0]    int_mask;
  logic [CT_W-1:0]    control;
  logic [NUM_ERR-1:0] err_mask;
  logic [NUM_ERR-1:0] severity;
  logic [31:0]        header_log;
  logic [2:0]         first_error_pointer;
  logic               ptr_valid;
  logic               rd_done;

  logic [NUM_ERR-1:0] err_hit;
  logic [NUM_ERR-1:0] err_live;
  logic [NUM_ERR-1:0] err_report;
  logic [ST_W-1:0]    set_bits;
  logic [ST_W-1:0]    clr_bits;
  logic               any_live;
  logic               any_fatal;
  logic               any_nonfatal;
  logic               msg_en_fatal;
  logic               msg_en_nonfatal;
  logic               msg_fatal;
  logic               msg_nonfatal;
  logic [2:0]         first_idx;
  logic [31:0]        first_hdr;
  logic               wr_hit;
  logic               peresp;
  logic               ude;

  assign peresp = control[CT_PERESP_EN];
  assign ude    = i_up_write.valid;

  // error event decode
  always_comb
  begin
    err_hit                 = '0;
    err_hit[ERR_TA_POSTED]  = i_ta_event.valid & i_ta_event.posted;
    err_hit[ERR_TA_NP]      = i_ta_event.valid & ~i_ta_event.posted;
    err_hit[ERR_UDE_NP]     = ude & ~i_up_write.posted;
    err_hit[ERR_UDE_POSTED] = ude & i_up_write.posted;
  end

  // per-source qualification by mask and reporting enables
  genvar g;
  generate
    for (g = 0; g < NUM_ERR; g++)
    begin : g_err
      assign err_live[g]   = err_hit[g] & ~err_mask[g];
      assign err_report[g] = err_live[g] &
        (control[CT_SYSTEM_ERROR_ENABLE] |
         (severity[g] ? control[CT_FATAL_EN]
                      : control[CT_NONFATAL_EN]));
    end
  endgenerate

  assign any_live     = |err_live;
  assign any_fatal    = |(err_hit & severity);
  assign any_nonfatal = |(err_hit & ~severity);
  assign msg_fatal    = |(err_report & severity);
  assign msg_nonfatal = |(err_report & ~severity);
  assign msg_en_fatal    = msg_fatal;
  assign msg_en_nonfatal = msg_nonfatal;

  // lowest live source is logged first when several collide
  always_comb
  begin
    first_idx = 3'h0;
    first_hdr = 32'h0000_0000;
    for (int k = NUM_ERR - 1; k >= 0; k--)
    begin
      if (err_live[k])
      begin
        first_idx = 3'(k);
        first_hdr = (k < ERR_UDE_NP) ? i_ta_event.header
                                     : i_up_write.header;
      end
    end
  end

  // status set terms
  always_comb
  begin
    set_bits                  = '0;
    set_bits[ST_RX_TA_SEC]    = i_ta_event.valid;
    set_bits[ST_RX_TA_UNC]    = i_ta_event.valid;
    set_bits[ST_DET_PAR]      = ude;
    set_bits[ST_UNC_DATA]     = ude;
    set_bits[ST_MDPE_DET]     = err_hit[ERR_UDE_POSTED] & peresp;
    set_bits[ST_MDPE_PRI]     = 1'b0;
    set_bits[ST_SIG_SERR]     = (msg_fatal | msg_nonfatal) &
                                control[CT_SYSTEM_ERROR_ENABLE];
    set_bits[ST_FATAL_DET]    = any_fatal;
    set_bits[ST_NONFATAL_DET] = any_nonfatal;
  end

  // avalon-mm slave: writes take one cycle, reads wait one cycle
  assign wr_hit            = i_avs_write;
  assign o_avs_waitrequest = i_avs_read & ~rd_done;
  assign clr_bits = (wr_hit && i_avs_address == ADDR_ERR_STATUS)
                  ? i_avs_writedata[ST_W-1:0] : '0;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rd_done <= 1'b0;
    else
      rd_done <= i_avs_read & ~rd_done;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read & ~rd_done)
    begin
      case (i_avs_address)
        ADDR_ERR_STATUS: o_avs_readdata <= 32'(status);
        ADDR_INT_MASK:   o_avs_readdata <= 32'(int_mask);
        ADDR_CONTROL:    o_avs_readdata <= 32'(control);
        ADDR_ERR_MASK:   o_avs_readdata <= 32'(err_mask);
        ADDR_SEVERITY:   o_avs_readdata <= 32'(severity);
        ADDR_HEADER_LOG: o_avs_readdata <= header_log;
        ADDR_FIRST_PTR:  o_avs_readdata <= {28'h000_0000, ptr_valid,
                                            first_error_pointer};
        default:         o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // sticky status: set wins over a write-one clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      status <= '0;
    else
      status <= (status & ~clr_bits) | set_bits;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      int_mask <= '0;
      control  <= CONTROL_RST;
      err_mask <= MASK_RST;
      severity <= SEV_RST;
    end
    else if (wr_hit)
    begin
      case (i_avs_address)
        ADDR_INT_MASK: int_mask <= i_avs_writedata[ST_W-1:0];
        ADDR_CONTROL:  control  <= i_avs_writedata[CT_W-1:0];
        ADDR_ERR_MASK: err_mask <= i_avs_writedata[NUM_ERR-1:0];
        ADDR_SEVERITY: severity <= i_avs_writedata[NUM_ERR-1:0];
        default:       ;
      endcase
    end
  end

  // first header capture; an error is logged only while the pointer is not valid
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ptr_valid           <= 1'b0;
      first_error_pointer <= 3'h0;
      header_log          <= 32'h0000_0000;
    end
    else if (any_live && !ptr_valid)
    begin
      ptr_valid           <= 1'b1;
      first_error_pointer <= first_idx;
      header_log          <= first_hdr;
    end
    else if (wr_hit && i_avs_address == ADDR_FIRST_PTR &&
             i_avs_writedata[PTR_VALID])
      ptr_valid <= 1'b0;
  end

  // downstream target-abort outcome
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_posted_drop <= 1'b0;
      o_ca_cpl      <= 1'b0;
    end
    else
    begin
      o_posted_drop <= err_hit[ERR_TA_POSTED];
      o_ca_cpl      <= err_hit[ERR_TA_NP];
    end
  end

  // error messages toward the express link
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_fatal_msg    <= 1'b0;
      o_nonfatal_msg <= 1'b0;
    end
    else
    begin
      o_fatal_msg    <= msg_en_fatal;
      o_nonfatal_msg <= msg_en_nonfatal;
    end
  end

  // upstream write forwarding with poisoning
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      o_up_fwd     <= '0;
      o_perr_out   <= 1'b0;
      o_perr_oe    <= 1'b0;
      o_np_discard <= 1'b0;
    end
    else
    begin
      // discard only a non-posted write with response enabled
      o_up_fwd.valid    <= ude & ~(~i_up_write.posted & peresp);
      o_up_fwd.poisoned <= ude;
      o_up_fwd.header   <= i_up_write.header;
      o_up_fwd.data     <= i_up_write.data;
      o_perr_out        <= 1'b0; // driven low means asserted
      o_perr_oe         <= ude & peresp;
      o_np_discard      <= ude & ~i_up_write.posted & peresp;
    end
  end

  // delayed transaction completion translation
  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      o_dt_rsp <= '0;
    else
    begin
      o_dt_rsp.valid <= i_dt_cpl.valid;
      o_dt_rsp.rsp   <= BEF_RSP_NORMAL;
      o_dt_rsp.data  <= i_dt_cpl.data;
      if (i_dt_cpl.status == CPL_CA)
        o_dt_rsp.rsp <= BEF_RSP_TABORT;
      else if (i_dt_cpl.status == CPL_UR)
      begin
        if (control[CT_MA_MODE])
          o_dt_rsp.rsp <= BEF_RSP_TABORT;
        else if (i_dt_cpl.kind != BEF_DT_IO_WRITE)
          o_dt_rsp.data <= ALL_ONES;
      end
    end
  end

  assign o_irq = |(status & int_mask);

endmodule // bef_top
`default_nettype wire

// [bef_checker.sv]
// port-level assertions for the bridge error forwarding block
`timescale 1ns/1ps
`default_nettype none
module bef_checker
  import bef_pkg::*;
(
  input  wire logic            i_core_clk,
  input  wire logic            i_rst,
  input  wire bef_down_event_t i_ta_event,
  input  wire bef_up_write_t   i_up_write,
  input  wire bef_dt_cpl_t     i_dt_cpl,
  input  wire bef_up_fwd_t     o_up_fwd,
  input  wire bef_dt_rsp_t     o_dt_rsp,
  input  wire logic            o_posted_drop,
  input  wire logic            o_ca_cpl,
  input  wire logic            o_perr_out,
  input  wire logic            o_perr_oe,
  input  wire logic            o_fatal_msg,
  input  wire logic            o_nonfatal_msg
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  AST_POSTED_DROP:
    assert property (i_ta_event.valid && i_ta_event.posted
      |=> o_posted_drop && !o_ca_cpl) else $error("posted abort kept");
  AST_CA_CPL:
    assert property (i_ta_event.valid && !i_ta_event.posted
      |=> o_ca_cpl && !o_posted_drop) else $error("no abort completion");
  AST_UP_POISON:
    assert property (i_up_write.valid && i_up_write.posted
      |=> o_up_fwd.valid && o_up_fwd.poisoned) else $error("not poisoned");
  AST_FWD_CAUSE:
    assert property (o_up_fwd.valid |-> $past(i_up_write.valid)
      && o_up_fwd.data == $past(i_up_write.data)) else $error("stray fwd");
  AST_PERR_PIN:
    assert property (o_perr_oe |-> !o_perr_out && $past(i_up_write.valid))
      else $error("stray parity pin drive");
  AST_NP_DISCARD:
    assert property (i_up_write.valid && !i_up_write.posted
      |=> o_perr_oe != o_up_fwd.valid) else $error("np discard wrong");
  AST_DT_CA:
    assert property (i_dt_cpl.valid && i_dt_cpl.status == CPL_CA
      |=> o_dt_rsp.valid && o_dt_rsp.rsp == BEF_RSP_TABORT)
      else $error("completer abort not aborted");
  AST_DT_CAUSE:
    assert property (o_dt_rsp.valid |-> $past(i_dt_cpl.valid))
      else $error("stray delayed response");
  AST_MSG_CAUSE:
    assert property (o_fatal_msg || o_nonfatal_msg
      |-> $past(i_ta_event.valid || i_up_write.valid))
      else $error("stray error message");
endmodule // bef_checker
`default_nettype wire

// [bef_far_end.sv]
// far-side model: abort, parity error and completion events
`timescale 1ns/1ps
`default_nettype none
module bef_far_end
  import bef_pkg::*;
(
  input  wire logic             i_core_clk,
  output var bef_down_event_t   o_ta,
  output var bef_up_write_t     o_up,
  output var bef_dt_cpl_t       o_dt
);
  initial
  begin
    o_ta = '0;
    o_up = '0;
    o_dt = '0;
  end
  // idle payload is inverted so a design sampling it late sees garbage
  task automatic send_ta(input logic p, input logic [31:0] h);
    @(posedge i_core_clk);
    o_ta <= '{1'b1, p, h};
    @(posedge i_core_clk);
    o_ta <= '{1'b0, p, ~h};
  endtask
  task automatic send_up(input logic p, input logic [31:0] h,
                         input logic [31:0] d);
    @(posedge i_core_clk);
    o_up <= '{1'b1, p, h, d};
    @(posedge i_core_clk);
    o_up <= '{1'b0, p, ~h, ~d};
  endtask
  task automatic send_dt(input bef_dt_kind_t k, input logic [2:0] s,
                         input logic [31:0] d);
    @(posedge i_core_clk);
    o_dt <= '{1'b1, k, s, d};
    @(posedge i_core_clk);
    o_dt <= '{1'b0, k, s, ~d};
  endtask
endmodule // bef_far_end
`default_nettype wire

// [test_bef_top.sv]
// self-checking bench for the bridge error forwarding block
`timescale 1ns/1ps
`default_nettype none
module test_bef_top
  import bef_pkg::*;
;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [3:0]      addr = 4'h0;
  logic            rd = 1'b0;
  logic            wr = 1'b0;
  logic [31:0]     wdata = 32'h0000_0000;
  logic [31:0]     rdata, q;
  logic            wait_req, drop, ca, perr, perr_oe, fmsg, nmsg, irq;
  logic            np_disc;
  bef_down_event_t ta;
  bef_up_write_t   up;
  bef_dt_cpl_t     dt;
  bef_up_fwd_t     fwd;
  bef_dt_rsp_t     rsp;
  int              n_fail = 0;
  int              compares = 0;
  always #50 clk = ~clk;
  bef_far_end i_far (.i_core_clk(clk), .o_ta(ta), .o_up(up), .o_dt(dt));
  bef_top i_dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_ta_event(ta), .i_up_write(up), .i_dt_cpl(dt), .o_up_fwd(fwd),
    .o_dt_rsp(rsp), .o_posted_drop(drop), .o_ca_cpl(ca),
    .o_np_discard(np_disc), .o_perr_out(perr), .o_perr_oe(perr_oe),
    .o_fatal_msg(fmsg), .o_nonfatal_msg(nmsg), .o_irq(irq));
  function automatic logic [31:0] bit_of(input int i);
    return 32'h0000_0001 << i;
  endfunction
  task automatic final_report();
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waitrequest and read data are both taken at the rising edge itself
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 20)
    begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic clear_all();
    bus(1'b1, ADDR_ERR_STATUS, 32'h0000_01FF);
    bus(1'b1, ADDR_FIRST_PTR, bit_of(PTR_VALID));
  endtask
  task automatic s_ta();
    logic [31:0] e;
    e = bit_of(ST_RX_TA_SEC) | bit_of(ST_RX_TA_UNC) | bit_of(ST_SIG_SERR);
    bus(1'b1, ADDR_CONTROL, bit_of(CT_SYSTEM_ERROR_ENABLE));
    i_far.send_ta(1'b1, 32'h1111_0001);
    #1 chk("drop", 1, drop);
    chk("nonfatal msg", 1, nmsg);
    bus(1'b1, ADDR_SEVERITY, bit_of(ERR_TA_NP));
    i_far.send_ta(1'b0, 32'h2222_0002);
    #1 chk("abort cpl", 1, ca);
    chk("fatal msg", 1, fmsg);
    e = e | bit_of(ST_FATAL_DET) | bit_of(ST_NONFATAL_DET);
    rchk("status", ADDR_ERR_STATUS, e);
    rchk("header", ADDR_HEADER_LOG, 32'h1111_0001);
    rchk("pointer", ADDR_FIRST_PTR, bit_of(PTR_VALID) | ERR_TA_POSTED);
    bus(1'b1, ADDR_SEVERITY, 32'h0000_0000);
    clear_all();
    rchk("cleared", ADDR_ERR_STATUS, 32'h0000_0000);
  endtask
  task automatic s_mask();
    logic [31:0] e;
    e = bit_of(ST_RX_TA_SEC) | bit_of(ST_RX_TA_UNC) | bit_of(ST_NONFATAL_DET);
    bus(1'b1, ADDR_ERR_MASK, bit_of(ERR_TA_POSTED));
    i_far.send_ta(1'b1, 32'h4444_0004);
    #1 chk("masked msg", 0, nmsg | fmsg);
    rchk("masked ptr", ADDR_FIRST_PTR, 32'h0000_0000);
    rchk("masked st", ADDR_ERR_STATUS, e);
    bus(1'b1, ADDR_ERR_MASK, 32'h0000_0000);
    bus(1'b1, ADDR_CONTROL, bit_of(CT_NONFATAL_EN));
    i_far.send_ta(1'b1, 32'h4444_0005);
    #1 chk("report msg", 1, nmsg);
    rchk("no serr", ADDR_ERR_STATUS, e);
    clear_all();
  endtask
  task automatic s_ude();
    bus(1'b1, ADDR_CONTROL, bit_of(CT_PERESP_EN));
    i_far.send_up(1'b1, 32'h3333_0003, 32'h5A5A_0003);
    #1 chk("poisoned", 2'b11, {fwd.valid, fwd.poisoned});
    chk("fwd data", 32'h5A5A_0003, fwd.data);
    chk("perr posted", 1, perr_oe);
    chk("posted no discard", 0, np_disc);
    rchk("posted st", ADDR_ERR_STATUS, 32'h0000_011C);
    clear_all();
    i_far.send_up(1'b0, 32'h3333_0004, 32'h5A5A_0004);
    #1 chk("np discard", 3'b011, {fwd.valid, perr_oe, np_disc});
    rchk("np st", ADDR_ERR_STATUS, 32'h0000_010C);
    clear_all();
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    i_far.send_up(1'b0, 32'h3333_0005, 32'h5A5A_0005);
    #1 chk("np poison", 4'b1100,
           {fwd.valid, fwd.poisoned, perr_oe, np_disc});
    clear_all();
  endtask
  task automatic s_dt();
    bef_dt_kind_t k[4] = '{BEF_DT_MEM_READ, BEF_DT_IO_READ,
                           BEF_DT_IO_WRITE, BEF_DT_MEM_READ};
    logic [2:0]   st[4] = '{CPL_UR, CPL_UR, CPL_UR, CPL_CA};
    logic         ab;
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, ADDR_CONTROL, m ? bit_of(CT_MA_MODE) : 32'h0000_0000);
      for (int i = 0; i < 4; i++)
      begin
        i_far.send_dt(k[i], st[i], 32'h0000_1234);
        ab = (st[i] == CPL_CA) || (m == 1);
        #1 chk("dt rsp", {1'b1, ab ? BEF_RSP_TABORT : BEF_RSP_NORMAL},
               {rsp.valid, rsp.rsp});
        if (!ab && k[i] != BEF_DT_IO_WRITE)
          chk("dt data", ALL_ONES, rsp.data);
      end
    end
  endtask
  task automatic s_irq();
    bus(1'b1, ADDR_INT_MASK, bit_of(ST_RX_TA_SEC));
    i_far.send_ta(1'b1, 32'h6666_0006);
    @(posedge clk);
    #1 chk("irq set", 1, irq);
    bus(1'b1, ADDR_INT_MASK, 32'h0000_0000);
    #1 chk("irq masked", 0, irq);
    bus(1'b1, ADDR_INT_MASK, bit_of(ST_RX_TA_SEC));
    #1 chk("irq held", 1, irq);
    clear_all();
    #1 chk("irq clear", 0, irq);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("control rst", ADDR_CONTROL, {27'h000_0000, CONTROL_RST});
    rchk("unmapped", 4'hF, 32'h0000_0000);
    s_ta();
    s_mask();
    s_ude();
    s_dt();
    s_irq();
    final_report();
  end
endmodule // test_bef_top
bind bef_top bef_checker u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_ta_event(i_ta_event), .i_up_write(i_up_write), .i_dt_cpl(i_dt_cpl),
  .o_up_fwd(o_up_fwd), .o_dt_rsp(o_dt_rsp), .o_posted_drop(o_posted_drop),
  .o_ca_cpl(o_ca_cpl), .o_perr_out(o_perr_out), .o_perr_oe(o_perr_oe),
  .o_fatal_msg(o_fatal_msg), .o_nonfatal_msg(o_nonfatal_msg));
`default_nettype wire
